// File: cpm_pkg.sv
/*
 * cpm_pkg: constants and types for the codec port pin multiplexer.
 * Assumes a single 40 MHz clock domain and a 32-bit Avalon-MM slave.
 */
`default_nettype none

package cpm_pkg;

  // register byte offsets
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;

  // configuration field positions
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int FS_DIR_BIT = 3;
  localparam int CLK_DIR_BIT = 4;
  localparam int PULLUP_BIT = 5;
  localparam int CFG_W = 6;
  localparam logic [5:0] CFG_RST = 6'h00;

  // status field positions
  localparam int ST_OPM_LSB = 0;
  localparam int ST_IRQ_BIT = 2;
  localparam int ST_USBR_BIT = 3;
  localparam int ST_OE_LSB = 8;
  localparam int ST_PAD_LSB = 16;

  // reset values
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic WAIT_RST = 1'b1;
  localparam logic RESET_OUTPUT_RST = 1'b1;

  // synchroniser depth in front of any pad input
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CPM_OPM_INTERNAL = 2'b00,
    CPM_OPM_EXTCTRL  = 2'b01,
    CPM_OPM_TEST     = 2'b10
  } cpm_opmode_t;

  typedef enum logic [2:0] {
    CPM_M_GP      = 3'h0,
    CPM_M_SERIAL  = 3'h1,
    CPM_M_ACL1    = 3'h2,
    CPM_M_ACL2    = 3'h3,
    CPM_M_I2S_3O  = 3'h4,
    CPM_M_I2S_2O  = 3'h5,
    CPM_M_I2S_1O  = 3'h6,
    CPM_M_I2S_4O  = 3'h7
  } cpm_mode_t;

  // one bit per codec port terminal
  typedef struct packed {
    logic aux;
    logic rst;
    logic din;
    logic dout;
    logic sclk;
    logic sync;
  } cpm_pins_t;

  // output enables per mode, index = mode; gp sync/sclk set by software
  localparam logic [7:0][5:0] OE_MAP = {
    6'h3f, 6'h07, 6'h0f, 6'h1f, 6'h15, 6'h35, 6'h37, 6'h34
  };

  // modes in which the aux terminal has no function
  localparam logic [7:0] AUX_NC = 8'h05;

endpackage : cpm_pkg

`default_nettype wire

// File: cpm_pin_mux.sv
/*
 * cpm_pin_mux: pin control of the codec port, strap mode capture,
 * reset output, pull-up control and external interrupt input.
 * Assumes pads are resolved outside from out/oe, protocol engines
 * sit on i_clk, and straps are stable around reset release.
 */
// Contract
// [RULE_01] straps low/low give internal controller, high/low external controller
// [RULE_02] test strap high at reset gives factory test mode always
// [RULE_03] eight terminal setups chosen by the mode field of config
// [RULE_04] mode 0: data out and reset out, data in input, aux driven
// [RULE_05] only in mode 0 frame sync and bit clock direction programmable
// [RULE_06] mode 1: all outputs, aux frame control, data in input
// [RULE_07] ac-link: bit clock and data in inputs; mode 3 aux input
// [RULE_08] modes 4 and 7: clocks out, three or four data out
// [RULE_09] mode 5 two outputs two inputs; mode 6 one output
// [RULE_10] terminals without function are still driven as outputs
// [RULE_11] reset output active during master reset or usb bus reset
// [RULE_12] pull-up control drives high or floats to detach
// [RULE_13] external low level on interrupt input is a request
// [RULE_14] straps sampled at reset release, held until next reset
`default_nettype none

module cpm_pin_mux (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_usb_bus_reset,
  input wire logic i_ext_controller_strap,
  input wire logic i_test_strap,
  input wire logic i_ext_interrupt_in_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire cpm_pkg::cpm_pins_t i_eng_out,
  output cpm_pkg::cpm_pins_t o_eng_in,
  input wire cpm_pkg::cpm_pins_t i_pad_in,
  output cpm_pkg::cpm_pins_t o_pad_out,
  output cpm_pkg::cpm_pins_t o_pad_oe,
  output logic o_bitclk_rise,
  output logic o_reset_output,
  output logic o_dp_pullup_out,
  output logic o_dp_pullup_oe,
  output logic o_ext_irq,
  output cpm_pkg::cpm_opmode_t o_op_mode
);

  // pad synchronisers
  logic [5:0] pad_s1_r;
  logic [5:0] pad_s2_r;
  logic sclk_d_r;
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pad_sync
      always_ff @(posedge i_clk) begin
        pad_s1_r[gi] <= i_pad_in[gi];
        pad_s2_r[gi] <= pad_s1_r[gi];
      end
    end
  endgenerate

  // straps and interrupt are synchronised without reset so they are
  // valid at the release
  always_ff @(posedge i_clk) begin
    strap_s1_r <= {i_ext_interrupt_in_n, i_test_strap,
                   i_ext_controller_strap};
    strap_s2_r <= strap_s1_r;
  end

  wire ext_strap_s = strap_s2_r[0];
  wire test_strap_s = strap_s2_r[1];
  wire irq_n_s = strap_s2_r[2];

  // operating mode capture
  logic cap_done_r;
  cpm_pkg::cpm_opmode_t op_mode_r;
  cpm_pkg::cpm_opmode_t op_mode_nxt;

  always_comb begin
    unique case ({test_strap_s, ext_strap_s})
      2'b00: op_mode_nxt = cpm_pkg::CPM_OPM_INTERNAL; // see [RULE_01]
      2'b01: op_mode_nxt = cpm_pkg::CPM_OPM_EXTCTRL; // see [RULE_01]
      2'b10: op_mode_nxt = cpm_pkg::CPM_OPM_TEST; // see [RULE_02]
      2'b11: op_mode_nxt = cpm_pkg::CPM_OPM_TEST; // see [RULE_02]
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cap_done_r <= 1'b0;
      op_mode_r <= cpm_pkg::CPM_OPM_INTERNAL;
    end else if (!cap_done_r) begin
      cap_done_r <= 1'b1; // see [RULE_14]
      op_mode_r <= op_mode_nxt; // see [RULE_14]
    end
  end

  // avalon slave
  logic wait_r;
  logic [31:0] rdata_r;
  logic [cpm_pkg::CFG_W-1:0] cfg_r;

  wire req = i_avs_read | i_avs_write;
  wire accept = req & ~wait_r;
  wire hit_cfg = i_avs_address == cpm_pkg::CFG_OFS;
  wire hit_stat = i_avs_address == cpm_pkg::STAT_OFS;
  wire cfg_we = accept & i_avs_write & hit_cfg;

  wire cpm_pkg::cpm_mode_t mode =
    cpm_pkg::cpm_mode_t'(cfg_r[cpm_pkg::MODE_LSB +: cpm_pkg::MODE_W]);
  wire is_gp = mode == cpm_pkg::CPM_M_GP;

  // output enables from the mode map
  cpm_pkg::cpm_pins_t oe_r;
  cpm_pkg::cpm_pins_t out_r;
  cpm_pkg::cpm_pins_t oe_nxt;
  cpm_pkg::cpm_pins_t out_nxt;
  wire cpm_pkg::cpm_pins_t oe_base = cpm_pkg::OE_MAP[mode]; // see [RULE_03]
  wire aux_nc = cpm_pkg::AUX_NC[mode];

  always_comb begin
    oe_nxt = oe_base; // see [RULE_06] [RULE_07] [RULE_08] [RULE_09]
    if (is_gp) begin
      oe_nxt.sync = cfg_r[cpm_pkg::FS_DIR_BIT]; // see [RULE_05]
      oe_nxt.sclk = cfg_r[cpm_pkg::CLK_DIR_BIT]; // see [RULE_05]
    end
    out_nxt = i_eng_out & oe_nxt;
    if (aux_nc) begin
      out_nxt.aux = 1'b0; // see [RULE_04] [RULE_10]
    end
  end

  wire [31:0] stat_word = {10'h000, pad_s2_r, 2'h0, oe_r,
                           4'h0, o_reset_output, o_ext_irq, op_mode_r};
  wire [31:0] rd_mux = hit_cfg ? {26'h0000000, cfg_r} :
                       hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_r <= cpm_pkg::WAIT_RST;
      rdata_r <= cpm_pkg::RDATA_RST;
      cfg_r <= cpm_pkg::CFG_RST;
    end else begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r) begin
        rdata_r <= rd_mux;
      end
      if (cfg_we) begin
        cfg_r <= i_avs_writedata[cpm_pkg::CFG_W-1:0]; // see [RULE_03]
      end
    end
  end

  // pins, reset output, pull-up, interrupt
  logic reset_output_r;
  logic pull_oe_r;
  logic irq_r;
  logic rise_r;

  wire sclk_in = ~oe_r.sclk;

  always_ff @(posedge i_clk) begin
    sclk_d_r <= pad_s2_r[1];
    if (i_rst) begin
      oe_r <= cpm_pkg::cpm_pins_t'(cpm_pkg::OE_MAP[0]);
      out_r <= '0;
      reset_output_r <= cpm_pkg::RESET_OUTPUT_RST; // see [RULE_11]
      pull_oe_r <= 1'b0;
      irq_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt; // see [RULE_10]
      out_r <= out_nxt;
      reset_output_r <= i_usb_bus_reset; // see [RULE_11]
      pull_oe_r <= cfg_r[cpm_pkg::PULLUP_BIT]; // see [RULE_12]
      irq_r <= ~irq_n_s; // see [RULE_13]
      rise_r <= sclk_in & pad_s2_r[1] & ~sclk_d_r;
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata = rdata_r;
  assign o_pad_oe = oe_r;
  assign o_pad_out = out_r;
  assign o_eng_in = pad_s2_r;
  assign o_bitclk_rise = rise_r;
  assign o_reset_output = reset_output_r;
  assign o_dp_pullup_out = 1'b1;
  assign o_dp_pullup_oe = pull_oe_r;
  assign o_ext_irq = irq_r;
  assign o_op_mode = op_mode_r;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_strap_normal: assert property ( // see [RULE_01]
    !cap_done_r && !test_strap_s |=>
      o_op_mode == ($past(ext_strap_s) ? cpm_pkg::CPM_OPM_EXTCTRL
                                       : cpm_pkg::CPM_OPM_INTERNAL))
    else $error("strap decode wrong");

  a_strap_test: assert property ( // see [RULE_02]
    !cap_done_r && test_strap_s |=> o_op_mode == cpm_pkg::CPM_OPM_TEST)
    else $error("test strap ignored");

  a_mode_hold: assert property ( // see [RULE_14]
    cap_done_r |=> $stable(o_op_mode) && cap_done_r)
    else $error("operating mode changed");

  a_cfg_write: assert property ( // see [RULE_03]
    cfg_we |=> mode == $past(i_avs_writedata[2:0]))
    else $error("mode field not written");

  a_gp_fixed: assert property ( // see [RULE_04]
    is_gp |=> o_pad_oe.dout && o_pad_oe.rst && o_pad_oe.aux
              && !o_pad_oe.din)
    else $error("gp directions wrong");

  a_gp_prog: assert property ( // see [RULE_05]
    is_gp |=> o_pad_oe.sync == $past(cfg_r[3])
              && o_pad_oe.sclk == $past(cfg_r[4]))
    else $error("gp programmable direction wrong");

  a_fixed_dirs: assert property ( // see [RULE_05]
    !is_gp |=> o_pad_oe.sync && (o_pad_oe.sclk != $past(mode == 3'h2
                                                  || mode == 3'h3)))
    else $error("sync or clock direction wrong");

  a_serial_dirs: assert property ( // see [RULE_06]
    mode == cpm_pkg::CPM_M_SERIAL |=> o_pad_oe == 6'h37)
    else $error("serial codec directions wrong");

  a_aclink_dirs: assert property ( // see [RULE_07]
    mode == cpm_pkg::CPM_M_ACL1 || mode == cpm_pkg::CPM_M_ACL2 |=>
      !o_pad_oe.sclk && !o_pad_oe.din && o_pad_oe.dout
      && (o_pad_oe.aux == $past(mode == cpm_pkg::CPM_M_ACL1)))
    else $error("ac-link directions wrong");

  a_i2s_four: assert property ( // see [RULE_08]
    mode == cpm_pkg::CPM_M_I2S_3O || mode == cpm_pkg::CPM_M_I2S_4O |=>
      o_pad_oe[4:0] == 5'h1f
      && o_pad_oe.aux == $past(mode == cpm_pkg::CPM_M_I2S_4O))
    else $error("i2s 4/7 directions wrong");

  a_i2s_five: assert property ( // see [RULE_09]
    mode == cpm_pkg::CPM_M_I2S_2O || mode == cpm_pkg::CPM_M_I2S_1O |=>
      o_pad_oe[5:4] == 2'h0 && o_pad_oe[2:0] == 3'h7
      && o_pad_oe.din == $past(mode == cpm_pkg::CPM_M_I2S_2O))
    else $error("i2s 5/6 directions wrong");

  a_nc_driven: assert property ( // see [RULE_10]
    (mode == cpm_pkg::CPM_M_GP || mode == cpm_pkg::CPM_M_ACL1) |=>
      o_pad_oe.aux && !o_pad_out.aux)
    else $error("unused terminal not driven low");

  a_reset_output_usb: assert property ( // see [RULE_11]
    i_usb_bus_reset |=> o_reset_output)
    else $error("reset output does not follow usb reset");

  a_reset_output_idle: assert property ( // see [RULE_11]
    !i_usb_bus_reset |=> !o_reset_output)
    else $error("reset output stuck active");

  a_bus_answer: assert property ( // see [RULE_03]
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=>
      !o_avs_waitrequest)
    else $error("bus request not answered");

  a_bus_rearm: assert property ( // see [RULE_03]
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  a_out_masked: assert property ( // see [RULE_10]
    (o_pad_out & ~o_pad_oe) == 6'h00)
    else $error("output value on an input terminal");

  a_irq_clear: assert property ( // see [RULE_13]
    i_ext_interrupt_in_n [*3] |=> !o_ext_irq)
    else $error("interrupt request without low pin");

  a_rise_gated: assert property ( // see [RULE_07]
    o_bitclk_rise |-> $past(!o_pad_oe.sclk))
    else $error("bit clock edge while clock is driven");

  a_pullup: assert property ( // see [RULE_12]
    o_dp_pullup_out && (o_dp_pullup_oe == $past(cfg_r[5])))
    else $error("pull-up control wrong");

  a_irq_level: assert property ( // see [RULE_13]
    !i_ext_interrupt_in_n [*3] |=> o_ext_irq)
    else $error("interrupt request lost");

  c_ext_mode: cover property (cap_done_r && !$past(cap_done_r)
                              && o_op_mode == cpm_pkg::CPM_OPM_EXTCTRL);
  c_test_mode: cover property (o_op_mode == cpm_pkg::CPM_OPM_TEST);
  c_acl_rise: cover property (mode == cpm_pkg::CPM_M_ACL2
                              && o_bitclk_rise);
  c_all_out: cover property (o_pad_oe == 6'h3f);
  c_serial_mode: cover property (mode == cpm_pkg::CPM_M_SERIAL
                                 && o_pad_oe.aux);

endmodule : cpm_pin_mux

`default_nettype wire

// File: cpm_codec_model.sv
/* cpm_codec_model: behavioural codec on the six codec port terminals.
   Assumes the mux out/oe pair decides who owns each terminal. */
`default_nettype none
module cpm_codec_model (
  input wire logic i_run,
  input wire logic [5:0] i_data,
  input wire logic i_irq_req,
  input wire cpm_pkg::cpm_pins_t i_pad_out,
  input wire cpm_pkg::cpm_pins_t i_pad_oe,
  output cpm_pkg::cpm_pins_t o_pad_in,
  output logic o_irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bclk = 1'b0;
  logic [5:0] drv;
  // bit clock stands still outside frames
  always begin
    #100;
    bclk = i_run ? ~bclk : 1'b0;
  end
  assign drv = {i_data[5:2], bclk, i_data[0]};
  // codec drives every terminal the device leaves as input
  assign o_pad_in = cpm_pkg::cpm_pins_t'((i_pad_out & i_pad_oe) |
    (drv & ~i_pad_oe));
  assign o_irq_n = ~i_irq_req;
endmodule : cpm_codec_model
`default_nettype wire

// File: cpm_pin_mux_tb.sv
/* cpm_pin_mux_tb: self-checking bench for the codec port pin mux.
   Assumes the codec model on the pads and Avalon reads and writes. */
`default_nettype none
module cpm_pin_mux_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic usb_rst = 1'b0;
  logic ext_s = 1'b0;
  logic tst_s = 1'b0;
  logic irq_req = 1'b0;
  logic run = 1'b0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic waitreq, reset_output, pu_out, pu_oe, irq, brise, irq_n;
  logic [5:0] data = 6'h2d;
  logic [5:0] cfg;
  logic [5:0] eo;
  int c;
  cpm_pkg::cpm_pins_t eng_out = 6'h3f;
  cpm_pkg::cpm_pins_t eng_in, pad_in, pad_out, pad_oe;
  cpm_pkg::cpm_opmode_t op_mode;
  int err_count = 0;
  int n_tests = 0;

  always #12.5 i_clk = ~i_clk;

  cpm_pin_mux uut (.i_clk(i_clk), .i_rst(i_rst), .i_usb_bus_reset(usb_rst),
    .i_ext_controller_strap(ext_s), .i_test_strap(tst_s),
    .i_ext_interrupt_in_n(irq_n), .i_avs_address(addr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_eng_out(eng_out), .o_eng_in(eng_in),
    .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .o_bitclk_rise(brise), .o_reset_output(reset_output), .o_dp_pullup_out(pu_out),
    .o_dp_pullup_oe(pu_oe), .o_ext_irq(irq), .o_op_mode(op_mode));

  cpm_codec_model codec (.i_run(run), .i_data(data), .i_irq_req(irq_req),
    .i_pad_out(pad_out), .i_pad_oe(pad_oe), .o_pad_in(pad_in),
    .o_irq_n(irq_n));

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    rd_s <= ~w;
    wr_s <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
  endtask : bus

  task automatic do_reset(input logic e, input logic t);
    i_rst <= 1'b1;
    ext_s <= e;
    tst_s <= t;
    cyc(20);
    chk("reset_output_in_reset", 32'h1, {31'h0, reset_output});
    i_rst <= 1'b0;
    cyc(3);
  endtask : do_reset

  task automatic count_rises;
    c = 0;
    repeat (400) begin
      @(posedge i_clk);
      c += int'(brise);
    end
  endtask : count_rises

  // expected drive directions per mode
  function automatic logic [5:0] exp_oe(input logic [5:0] f);
    case (f[2:0])
      3'h0: exp_oe = {4'hd, f[4], f[3]};
      3'h1: exp_oe = 6'h37;
      3'h2: exp_oe = 6'h35;
      3'h3: exp_oe = 6'h15;
      3'h4: exp_oe = 6'h1f;
      3'h5: exp_oe = 6'h0f;
      3'h6: exp_oe = 6'h07;
      default: exp_oe = 6'h3f;
    endcase
  endfunction : exp_oe

  initial begin
    for (int s = 0; s < 4; s++) begin
      do_reset(s[0], s[1]);
      eo = s[1] ? 6'h2 : {5'h0, s[0]};
      chk("op_mode", 32'(eo), 32'(op_mode));
      ext_s <= ~s[0];
      tst_s <= ~s[1];
      cyc(4);
      chk("op_mode_held", 32'(eo), 32'(op_mode));
    end
    do_reset(1'b0, 1'b0);
    usb_rst <= 1'b1;
    cyc(2);
    chk("reset_output_usb", 32'h1, {31'h0, reset_output});
    usb_rst <= 1'b0;
    cyc(2);
    chk("reset_output_idle", 32'h0, {31'h0, reset_output});
    irq_req <= 1'b1;
    cyc(5);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, 4'h4, 32'h0);
    chk("st_irq", 32'h1, {31'h0, q[2]});
    chk("st_reset_output", 32'h0, {31'h0, q[3]});
    irq_req <= 1'b0;
    cyc(5);
    chk("irq_off", 32'h0, {31'h0, irq});
    bus(1'b1, 4'hc, 32'h3f);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, 4'h0, 32'h0);
    chk("cfg_reset", 32'h0, q);
    for (int m = 0; m < 8; m++) begin
      for (int f = 0; f < 4; f++) begin
        cfg = {m[0], f[1:0], m[2:0]};
        bus(1'b1, 4'h0, {26'h0, cfg});
        cyc(5);
        eo = exp_oe(cfg);
        chk("pad_oe", 32'(eo), 32'(pad_oe));
        chk("pad_oe_dirs", 32'(eo), 32'(pad_oe));
        chk("pad_out", 32'(eo & ((m == 0 || m == 2) ? 6'h1f : 6'h3f)),
          32'(pad_out));
        chk("pad_in", 32'({data[5:2], 1'b0, data[0]} & ~eo),
          32'(eng_in & ~eo));
        chk("pullup", {31'h0, cfg[5]}, {31'h0, pu_oe & pu_out});
        bus(1'b0, 4'h0, 32'h0);
        chk("cfg_rd", 32'(cfg), q);
        bus(1'b0, 4'h4, 32'h0);
        chk("st_oe", 32'(eo), 32'(q[13:8]));
        chk("st_pad", 32'((eo & ((m == 0 || m == 2) ? 6'h1f : 6'h3f)) |
          ({data[5:2], 1'b0, data[0]} & ~eo)),
          32'(q[21:16]));
      end
    end
    bus(1'b1, 4'h0, 32'h02);
    run <= 1'b1;
    count_rises();
    chk("bclk_in", 32'h1, {31'h0, c >= 48 && c <= 51});
    bus(1'b1, 4'h0, 32'h04);
    cyc(5);
    count_rises();
    chk("bclk_out", 32'h0, 32'(c));
    run <= 1'b0;
    print_verdict();
  end
endmodule : cpm_pin_mux_tb
`default_nettype wire
